/* File: asc_pkg.sv */
// asc_pkg: constants, types and decode helpers for the self-calibration sequencer
`default_nettype none
package asc_pkg;

	// =============================================
	// register map (word index on the plain register port)
	localparam logic [2:0] ADDR_COMM = 3'h0;
	localparam logic [2:0] ADDR_SETUP = 3'h1;
	localparam logic [2:0] ADDR_DATA = 3'h2;
	localparam logic [2:0] ADDR_ZS_CAL = 3'h3;
	localparam logic [2:0] ADDR_FS_CAL = 3'h4;
	localparam logic [2:0] ADDR_STATUS = 3'h5;

	// =============================================
	// field positions
	localparam int COMM_GAIN_LO = 0;
	localparam int COMM_GAIN_HI = 1;
	localparam int SETUP_UNIPOLAR = 2;
	localparam int SETUP_RATE_LO = 4;
	localparam int SETUP_RATE_HI = 5;
	localparam int SETUP_MODE_LO = 6;
	localparam int SETUP_MODE_HI = 7;
	localparam int STAT_READY_N = 0;
	localparam int STAT_CAL_BUSY = 1;
	localparam int STAT_ZS_STEP = 2;
	localparam int STAT_FS_STEP = 3;
	localparam int STAT_SETTLE = 4;

	// =============================================
	// widths and reset values
	localparam int RAW_W = 24;
	localparam int OUT_W = 16;
	localparam int COEF_W = 33;
	localparam int PROD_W = 59;
	localparam logic [7:0] COMM_RST = 8'h00;
	localparam logic [7:0] SETUP_RST = 8'h04;
	localparam logic [RAW_W-1:0] ZS_CAL_RST = 24'h00_0000;
	localparam logic [RAW_W-1:0] FS_CAL_RST = 24'h80_0000;
	localparam logic [COEF_W-1:0] COEF_RST = 33'h0_0000_0200;
	localparam logic [COEF_W-1:0] COEF_MAX = 33'h1_FFFF_FFFF;
	localparam logic [1:0] MODE_NORMAL = 2'b00;
	localparam logic [1:0] MODE_SELF_CAL = 2'b01;
	localparam logic [OUT_W-1:0] CODE_MID = 16'h8000;
	localparam logic [OUT_W-1:0] CODE_MAX = 16'hFFFF;

	// =============================================
	// timing: clk_sys is the master clock, 40 MHz
	localparam int CLK_HZ = 40_000_000;
	localparam int MOD_DIV = 128;
	localparam logic [6:0] MOD_LAST = 7'(MOD_DIV - 1);
	localparam int MOD_HZ = CLK_HZ / MOD_DIV;
	localparam int STEP_PERIODS = 3;
	localparam logic [1:0] STEP_LAST = 2'(STEP_PERIODS - 1);
	localparam int DIV_STEPS = COEF_W;
	localparam logic [5:0] DIV_LAST = 6'(DIV_STEPS - 1);
	// modulator cycles per output word for each rate select code
	localparam logic [8:0] DECIM_0 = 9'd384;
	localparam logic [8:0] DECIM_1 = 9'd320;
	localparam logic [8:0] DECIM_2 = 9'd77;
	localparam logic [8:0] DECIM_3 = 9'd38;

	typedef enum {ST_RUN, ST_ZS, ST_FS, ST_SETTLE} asc_state_t;

	function automatic logic [8:0] asc_decim(input logic [1:0] rate_sel);
		case (rate_sel)
			2'b00: asc_decim = DECIM_0;
			2'b01: asc_decim = DECIM_1;
			2'b10: asc_decim = DECIM_2;
			default: asc_decim = DECIM_3;
		endcase
	endfunction : asc_decim

	function automatic logic [OUT_W-1:0] asc_clamp(input logic signed [PROD_W-1:0] v);
		if (v < 0)
			asc_clamp = '0;
		else if (v > $signed({{(PROD_W-OUT_W){1'b0}}, CODE_MAX}))
			asc_clamp = CODE_MAX;
		else
			asc_clamp = v[OUT_W-1:0];
	endfunction : asc_clamp

endpackage : asc_pkg
`default_nettype wire

/* File: asc_tick_if.sv */
// asc_tick_if: timing ticks between the sequencer and its rate timer
`default_nettype none
interface asc_tick_if;
	logic restart;
	logic [1:0] rate_sel;
	logic mod_tick;
	logic out_tick;

	modport timer (input restart, input rate_sel, output mod_tick, output out_tick);
	modport seq (output restart, output rate_sel, input mod_tick, input out_tick);
endinterface : asc_tick_if
`default_nettype wire

/* File: asc_rate_timer.sv */
// asc_rate_timer: modulator-cycle prescaler and output-rate period counter
`default_nettype none
module asc_rate_timer (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// ticks
	asc_tick_if.timer tick
);

	// =============================================
	// counters
	logic [6:0] pre_cnt;
	logic [8:0] dec_cnt;
	wire pre_wrap = (pre_cnt == asc_pkg::MOD_LAST);
	wire [8:0] dec_last = asc_pkg::asc_decim(tick.rate_sel) - 9'd1;
	// a rate change to a period already exceeded ends it at the next wrap, never later
	wire dec_wrap = pre_wrap && (dec_cnt >= dec_last);

	assign tick.mod_tick = clk_en && pre_wrap && !tick.restart;
	assign tick.out_tick = clk_en && dec_wrap && !tick.restart;

	// restart re-aligns the period so a calibration step spans whole periods
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			pre_cnt <= '0;
			dec_cnt <= '0;
		end else if (clk_en) begin
			if (tick.restart) begin
				pre_cnt <= '0;
				dec_cnt <= '0;
			end else begin
				pre_cnt <= pre_wrap ? 7'd0 : pre_cnt + 7'd1;
				if (pre_wrap)
					dec_cnt <= dec_wrap ? 9'd0 : dec_cnt + 9'd1;
			end
		end
	end

endmodule : asc_rate_timer
`default_nettype wire

/* File: asc_cal_seq.sv */
// asc_cal_seq: self-calibration sequencer, coefficient set-up and result scaling
// =============================================
// Overview of operation
// - calibration write accepted at any time
// - mode code 0,1 starts self-calibration
// - zero step shorts inputs at bias
// - zero step uses selected gain
// - full step converts reference over gain
// - six periods: three zero, three full
// - mode bits clear to 0,0 when done
// - ready high from start until new word
// - ready low nine periods after command
// - ready goes high within one modulator cycle
// - store zero and full results separately
// - 33-bit coefficient math gives 16-bit result
// - bipolar: shorted point is midscale
// - modulator rate is master clock over 128
// - polarity changes coding only, not input
// - rate select sets output period
`default_nettype none
module asc_cal_seq (
	// clock, reset, enable
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [23:0] reg_rdata,
	// filter output word, one per output period
	input wire logic [23:0] filt_word,
	// analog front-end control
	output logic short_inputs,
	output logic fs_ref_sel,
	output logic [1:0] input_gain_amp,
	// data ready to host
	output logic conv_ready_n
);

	// =============================================
	// registers and state
	logic [7:0] comm_reg;
	logic [7:0] setup_reg;
	logic [asc_pkg::OUT_W-1:0] data_reg;
	logic [asc_pkg::RAW_W-1:0] zs_cal;
	logic [asc_pkg::RAW_W-1:0] fs_cal;
	logic [asc_pkg::COEF_W-1:0] coef;
	asc_pkg::asc_state_t state;
	asc_pkg::asc_state_t next_state;
	logic [1:0] per_cnt;

	// divider working set
	logic div_busy;
	logic [5:0] div_cnt;
	logic [asc_pkg::RAW_W+1:0] div_rem;
	logic [asc_pkg::COEF_W-1:0] div_quo;
	logic [asc_pkg::RAW_W:0] div_span;

	// =============================================
	// timer
	asc_tick_if tick ();

	asc_rate_timer u_timer (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.tick(tick)
	);

	// =============================================
	// register decode
	wire wr_comm = reg_wr && (reg_addr == asc_pkg::ADDR_COMM);
	wire wr_setup = reg_wr && (reg_addr == asc_pkg::ADDR_SETUP);
	wire rd_data = reg_rd && (reg_addr == asc_pkg::ADDR_DATA);
	wire [1:0] wr_mode = {reg_wdata[asc_pkg::SETUP_MODE_HI], reg_wdata[asc_pkg::SETUP_MODE_LO]};
	wire cal_cmd = wr_setup && (wr_mode == asc_pkg::MODE_SELF_CAL);
	wire [1:0] gain_sel = {comm_reg[asc_pkg::COMM_GAIN_HI], comm_reg[asc_pkg::COMM_GAIN_LO]};
	wire [1:0] rate_sel = {setup_reg[asc_pkg::SETUP_RATE_HI], setup_reg[asc_pkg::SETUP_RATE_LO]};
	wire unipolar = setup_reg[asc_pkg::SETUP_UNIPOLAR];
	wire cal_busy = (state != asc_pkg::ST_RUN);
	wire step_end = tick.out_tick && (per_cnt == asc_pkg::STEP_LAST);

	assign tick.restart = clk_en && cal_cmd;
	assign tick.rate_sel = rate_sel;

	// =============================================
	// analog control: short for zero step, reference/gain for full step
	assign short_inputs = (state == asc_pkg::ST_ZS);
	assign fs_ref_sel = (state == asc_pkg::ST_FS);
	// gain follows the selection in every step, polarity never reaches the inputs
	assign input_gain_amp = gain_sel;

	// =============================================
	// sequencer
	always_comb begin
		next_state = state;
		case (state)
			asc_pkg::ST_RUN: next_state = asc_pkg::ST_RUN;
			asc_pkg::ST_ZS: if (step_end) next_state = asc_pkg::ST_FS;
			asc_pkg::ST_FS: if (step_end) next_state = asc_pkg::ST_SETTLE;
			asc_pkg::ST_SETTLE: if (step_end) next_state = asc_pkg::ST_RUN;
			default: next_state = asc_pkg::ST_RUN;
		endcase
		if (cal_cmd)
			next_state = asc_pkg::ST_ZS;
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state <= asc_pkg::ST_RUN;
			per_cnt <= '0;
		end else if (clk_en) begin
			state <= next_state;
			if (cal_cmd || step_end)
				per_cnt <= '0;
			else if (tick.out_tick && cal_busy)
				per_cnt <= per_cnt + 2'd1;
		end
	end

	// =============================================
	// control registers; mode bits self-clear at end of full step
	wire fs_done = (state == asc_pkg::ST_FS) && step_end;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			comm_reg <= asc_pkg::COMM_RST;
			setup_reg <= asc_pkg::SETUP_RST;
		end else if (clk_en) begin
			if (wr_comm)
				comm_reg <= reg_wdata[7:0];
			if (wr_setup) begin
				setup_reg <= reg_wdata[7:0];
				// only self-calibration is supported; other codes fall back to normal
				if (!cal_cmd) begin
					setup_reg[asc_pkg::SETUP_MODE_HI] <= 1'b0;
					setup_reg[asc_pkg::SETUP_MODE_LO] <= 1'b0;
				end
			end else if (fs_done) begin
				setup_reg[asc_pkg::SETUP_MODE_HI] <= 1'b0;
				setup_reg[asc_pkg::SETUP_MODE_LO] <= 1'b0;
			end
		end
	end

	// =============================================
	// calibration points
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			zs_cal <= asc_pkg::ZS_CAL_RST;
			fs_cal <= asc_pkg::FS_CAL_RST;
		end else if (clk_en && !cal_cmd && step_end) begin
			if (state == asc_pkg::ST_ZS)
				zs_cal <= filt_word;
			if (state == asc_pkg::ST_FS)
				fs_cal <= filt_word;
		end
	end

	// =============================================
	// coefficient set-up: 2^32 / span by restoring division, 33 steps
	// runs inside the settle conversion, so the old coefficient never mixes in
	wire [asc_pkg::RAW_W:0] span_now = {1'b0, filt_word} - {1'b0, zs_cal};
	wire span_bad = span_now[asc_pkg::RAW_W] || (span_now == '0);
	wire [asc_pkg::RAW_W+1:0] div_try = {div_rem[asc_pkg::RAW_W:0], div_quo[asc_pkg::COEF_W-1]};
	wire div_ge = (div_try >= {1'b0, div_span});
	wire [asc_pkg::RAW_W+1:0] div_sub = div_try - {1'b0, div_span};
	wire [asc_pkg::COEF_W-1:0] div_shift = {div_quo[asc_pkg::COEF_W-2:0], div_ge};

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			div_busy <= 1'b0;
			div_cnt <= '0;
			div_rem <= '0;
			div_quo <= '0;
			div_span <= '0;
			coef <= asc_pkg::COEF_RST;
		end else if (clk_en) begin
			if (cal_cmd) begin
				div_busy <= 1'b0;
			end else if (fs_done) begin
				if (span_bad) begin
					coef <= asc_pkg::COEF_MAX;
				end else begin
					div_busy <= 1'b1;
					div_cnt <= '0;
					div_rem <= '0;
					div_quo <= {1'b1, {(asc_pkg::COEF_W-1){1'b0}}};
					div_span <= span_now;
				end
			end else if (div_busy) begin
				div_rem <= div_ge ? div_sub : div_try;
				div_quo <= div_shift;
				div_cnt <= div_cnt + 6'd1;
				if (div_cnt == asc_pkg::DIV_LAST) begin
					div_busy <= 1'b0;
					coef <= div_shift;
				end
			end
		end
	end

	// =============================================
	// result scaling at 33-bit coefficient resolution
	wire signed [asc_pkg::RAW_W:0] diff = $signed({1'b0, filt_word}) - $signed({1'b0, zs_cal});
	wire signed [asc_pkg::PROD_W-1:0] prod = diff * $signed({1'b0, coef});
	wire signed [asc_pkg::PROD_W-1:0] uni_val = prod >>> 16;
	// bipolar: the shorted-input point lands on midscale
	wire signed [asc_pkg::PROD_W-1:0] bip_val = (prod >>> 17) +
		$signed({{(asc_pkg::PROD_W-asc_pkg::OUT_W){1'b0}}, asc_pkg::CODE_MID});
	wire [asc_pkg::OUT_W-1:0] conv_code = unipolar ? asc_pkg::asc_clamp(uni_val) :
		asc_pkg::asc_clamp(bip_val);
	wire new_word = tick.out_tick && !cal_cmd &&
		((state == asc_pkg::ST_RUN) || ((state == asc_pkg::ST_SETTLE) && step_end));

	// =============================================
	// data register and ready line; a new word beats a same-cycle read
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_reg <= '0;
			conv_ready_n <= 1'b1;
		end else if (clk_en) begin
			if (cal_cmd) begin
				conv_ready_n <= 1'b1;
			end else if (new_word) begin
				data_reg <= conv_code;
				conv_ready_n <= 1'b0;
			end else if (rd_data) begin
				conv_ready_n <= 1'b1;
			end
		end
	end

	// =============================================
	// read path, one cycle after the strobe; unmapped reads zero
	logic [23:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			asc_pkg::ADDR_COMM: rd_mux = {16'h0000, comm_reg};
			asc_pkg::ADDR_SETUP: rd_mux = {16'h0000, setup_reg};
			asc_pkg::ADDR_DATA: rd_mux = {8'h00, data_reg};
			asc_pkg::ADDR_ZS_CAL: rd_mux = zs_cal;
			asc_pkg::ADDR_FS_CAL: rd_mux = fs_cal;
			asc_pkg::ADDR_STATUS: begin
				rd_mux[asc_pkg::STAT_READY_N] = conv_ready_n;
				rd_mux[asc_pkg::STAT_CAL_BUSY] = cal_busy;
				rd_mux[asc_pkg::STAT_ZS_STEP] = (state == asc_pkg::ST_ZS);
				rd_mux[asc_pkg::STAT_FS_STEP] = (state == asc_pkg::ST_FS);
				rd_mux[asc_pkg::STAT_SETTLE] = (state == asc_pkg::ST_SETTLE);
			end
			default: rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= '0;
		else if (clk_en)
			reg_rdata <= reg_rd ? rd_mux : 24'h00_0000;
	end

endmodule : asc_cal_seq
`default_nettype wire

/* File: asc_cal_seq_assertions.sv */
// asc_cal_seq_assertions: port-level timing checks for the sequencer
`default_nettype none
module asc_cal_seq_chk (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic clk_en,
	// register port
	input wire logic [2:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [23:0] reg_rdata,
	// front end and ready
	input wire logic [23:0] filt_word,
	input wire logic short_inputs,
	input wire logic fs_ref_sel,
	input wire logic [1:0] input_gain_amp,
	input wire logic conv_ready_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);
	// ========
	// helper counters
	logic [1:0] rate;
	logic busy;
	logic [19:0] since;
	logic [19:0] zcnt;
	logic [19:0] fcnt;
	wire setup_wr = reg_wr && clk_en && reg_addr == asc_pkg::ADDR_SETUP;
	wire cal_wr = setup_wr && reg_wdata[7:6] == asc_pkg::MODE_SELF_CAL;
	wire [19:0] per = 20'(128 * (rate == 2'b00 ? 384 : rate == 2'b01 ? 320 : rate == 2'b10 ? 77 : 38));
	// slack of two cycles (three for ready): period edges may land one cycle either side
	wire z_ok = zcnt + 2 >= 3 * per && zcnt <= 3 * per + 2;
	wire f_ok = fcnt + 2 >= 3 * per && fcnt <= 3 * per + 2;
	wire r_ok = since + 3 >= 9 * per && since <= 9 * per + 3;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rate <= 2'b00;
			busy <= 1'b0;
			since <= '0;
			zcnt <= '0;
			fcnt <= '0;
		end else if (clk_en) begin
			if (setup_wr)
				rate <= reg_wdata[5:4];
			busy <= cal_wr || (busy && conv_ready_n);
			since <= cal_wr ? '0 : since + 1'b1;
			zcnt <= (cal_wr || !short_inputs) ? '0 : zcnt + 1'b1;
			fcnt <= fs_ref_sel ? fcnt + 1'b1 : '0;
		end
	end
	// ========
	// assertions
	a_cal_ready_high: assert property (cal_wr |=> conv_ready_n)
		else $error("ready low after calibration start");
	a_cal_zero_step: assert property (cal_wr |=> short_inputs && !fs_ref_sel)
		else $error("zero step not entered");
	a_steps_exclusive: assert property (!(short_inputs && fs_ref_sel))
		else $error("both steps active");
	a_gain_follows: assert property (reg_wr && clk_en && reg_addr == asc_pkg::ADDR_COMM
		|=> input_gain_amp == $past(reg_wdata[1:0])) else $error("gain not applied");
	a_zero_to_full: assert property ($fell(short_inputs) |-> fs_ref_sel)
		else $error("full step missing");
	a_zero_len: assert property ($fell(short_inputs) |-> z_ok)
		else $error("zero step length wrong");
	a_full_len: assert property ($fell(fs_ref_sel) && !$past(cal_wr) |-> f_ok)
		else $error("full step length wrong");
	a_ready_nine: assert property (busy && !conv_ready_n |-> r_ok)
		else $error("ready delay wrong");
	a_rdata_idle: assert property ($past(clk_en) && !$past(reg_rd) |-> reg_rdata == '0)
		else $error("read data outside read cycle");
	c_cal_start: cover property (cal_wr);
	c_cal_abort: cover property (busy && cal_wr);
	c_ready_done: cover property (busy && !conv_ready_n);
endmodule : asc_cal_seq_chk
bind asc_cal_seq asc_cal_seq_chk u_asc_cal_seq_chk (.clk_sys, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .filt_word, .short_inputs, .fs_ref_sel, .input_gain_amp, .conv_ready_n);
`default_nettype wire

/* File: asc_front_model.sv */
// asc_front_model: analog front end and filter as seen by the sequencer
`default_nettype none
module asc_front_model (
	// front-end control
	input wire logic short_inputs,
	input wire logic fs_ref_sel,
	input wire logic [1:0] input_gain_amp,
	// levels from the bench
	input wire logic [23:0] zero_code,
	input wire logic [23:0] full_code,
	input wire logic [23:0] sig_code,
	// filter word
	output logic [23:0] filt_word
);
	// ========
	// input selection
	// gain leaks into the full point so a wrong gain shows in the stored value
	assign filt_word = short_inputs ? zero_code
		: fs_ref_sel ? full_code + 24'(input_gain_amp)
		: sig_code;
endmodule : asc_front_model
`default_nettype wire

/* File: asc_cal_seq_tb.sv */
// asc_cal_seq_tb: self-checking bench for the self-calibration sequencer
`default_nettype none
module asc_cal_seq_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PER = 128 * 38;
	localparam int LIMIT = 98000;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic clk_en = 1'b1;
	logic [2:0] reg_addr = '0;
	logic [23:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [23:0] zero_code = '0;
	logic [23:0] full_code = '0;
	logic [23:0] sig_code = '0;
	logic [23:0] reg_rdata;
	logic [23:0] filt_word;
	logic short_inputs;
	logic fs_ref_sel;
	logic conv_ready_n;
	logic [1:0] input_gain_amp;
	logic [1:0] gain;
	int failures = 0;
	int num_checks = 0;
	int cyc_n = 0;
	int t0 = 0;
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == LIMIT) begin
			failures++;
			conclude();
		end
	end
	asc_cal_seq u_asc_cal_seq (.clk_sys, .rst_b, .clk_en, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.filt_word, .short_inputs, .fs_ref_sel, .input_gain_amp, .conv_ready_n);
	asc_front_model u_asc_front_model (.short_inputs, .fs_ref_sel, .input_gain_amp, .zero_code, .full_code,
		.sig_code, .filt_word);
	// ========
	// checking and bus tasks
	task automatic conclude();
		if (failures == 0 && num_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [23:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		t0 = cyc_n;
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, input logic [23:0] exp, input string what);
		@(posedge clk_sys);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		chk(what, exp, reg_rdata);
	endtask : rd
	task automatic at(input int k);
		while (cyc_n - t0 < k)
			@(posedge clk_sys);
		@(negedge clk_sys);
	endtask : at
	// ========
	// reference result: offset and slope from the two stored points
	function automatic logic [23:0] model(input longint raw, input longint zs, input longint fs, input bit uni);
		longint coef;
		longint v;
		coef = (fs > zs) ? (64'd1 << 32) / (fs - zs) : 64'h1_ffff_ffff;
		v = uni ? ((raw - zs) * coef) >>> 16 : 32768 + (((raw - zs) * coef) >>> 17);
		return 24'(v < 0 ? 0 : v > 65535 ? 65535 : v);
	endfunction : model
	task automatic cal(input logic [23:0] setup, input bit uni);
		logic [23:0] zc;
		logic [23:0] fc;
		@(posedge clk_sys);
		zc = 24'($urandom % 32'h0010_0000);
		fc = zc + 24'h40_0000 + 24'($urandom % 32'h0040_0000);
		zero_code <= zc;
		full_code <= fc;
		sig_code <= zc + 24'($urandom % 32'(fc - zc + 24'h00_1000));
		if (!uni)
			while (conv_ready_n !== 1'b0 && cyc_n - t0 < PER * 12)
				@(negedge clk_sys);
		wr(asc_pkg::ADDR_SETUP, setup);
		if (uni) begin
			at(PER / 4);
			wr(asc_pkg::ADDR_SETUP, setup);
		end
		at(1);
		chk("ready_start", 24'h1, 24'(conv_ready_n));
		at(PER * 3 / 2);
		chk("zero_step", 24'h2, 24'({short_inputs, fs_ref_sel}));
		rd(asc_pkg::ADDR_STATUS, 24'h00_0007, "status_zero");
		at(PER * 9 / 2);
		chk("full_step", 24'h1, 24'({short_inputs, fs_ref_sel}));
		rd(asc_pkg::ADDR_ZS_CAL, zc, "zero_cal");
		at(PER * 6 - 100);
		rd(asc_pkg::ADDR_SETUP, setup, "mode_busy");
		at(PER * 6 + 100);
		rd(asc_pkg::ADDR_SETUP, setup & 24'h00_003f, "mode_done");
		rd(asc_pkg::ADDR_FS_CAL, fc + 24'(gain), "full_cal");
		chk("steps_off", 24'h0, 24'({short_inputs, fs_ref_sel}));
		while (conv_ready_n === 1'b1 && cyc_n - t0 < PER * 10)
			@(negedge clk_sys);
		chk("ready_delay", 24'h1, 24'(cyc_n - t0 >= PER * 9 - 2 && cyc_n - t0 <= PER * 9 + 2));
		rd(asc_pkg::ADDR_DATA, model(sig_code, zc, fc + 24'(gain), uni), "data");
		chk("ready_read", 24'h1, 24'(conv_ready_n));
	endtask : cal
	// ========
	// main sequence
	initial begin
		void'($urandom(32'hd58a_f903));
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		rd(asc_pkg::ADDR_COMM, 24'(asc_pkg::COMM_RST), "comm_rst");
		rd(asc_pkg::ADDR_SETUP, 24'(asc_pkg::SETUP_RST), "setup_rst");
		rd(asc_pkg::ADDR_ZS_CAL, asc_pkg::ZS_CAL_RST, "zero_rst");
		rd(asc_pkg::ADDR_FS_CAL, asc_pkg::FS_CAL_RST, "full_rst");
		rd(3'h6, 24'h00_0000, "unmapped");
		gain = 2'($urandom);
		wr(asc_pkg::ADDR_COMM, {22'h0, gain});
		@(negedge clk_sys);
		chk("gain", 24'(gain), 24'(input_gain_amp));
		// a write while the enable is low must leave the register alone
		@(posedge clk_sys);
		clk_en <= 1'b0;
		wr(asc_pkg::ADDR_COMM, {22'h0, ~gain});
		clk_en <= 1'b1;
		rd(asc_pkg::ADDR_COMM, {22'h0, gain}, "comm_frozen");
		wr(asc_pkg::ADDR_SETUP, 24'h00_00b4);
		rd(asc_pkg::ADDR_SETUP, 24'h00_0034, "setup_other");
		cal(24'h00_0074, 1'b1);
		cal(24'h00_0070, 1'b0);
		conclude();
	end
endmodule : asc_cal_seq_tb
`default_nettype wire
